// [wdg_pkg.sv]
// Purpose: Shared constants and types for the watchdog period and sleep-wake block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package wdg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CONTROL  = 4'h0;
    localparam logic [3:0] OFF_STATUS   = 4'h4;
    localparam logic [3:0] OFF_IRQ_EN   = 4'h8;
    localparam logic [3:0] OFF_IRQ_CLR  = 4'hC;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int          PS_LSB      = 1;
    localparam int          PS_W        = 5;
    localparam int          SWEN_BIT    = 0;
    localparam logic [4:0]  PS_RESET    = 5'h0B;
    localparam logic [4:0]  PS_MAX      = 5'h12;
    localparam int          PS_BASE_LOG = 5;
    localparam logic [1:0]  MODE_SW     = 2'h1;

    // ------------------------------------------------------------
    // Status and interrupt bits
    // ------------------------------------------------------------
    localparam int          ST_TIMEOUT  = 0;
    localparam int          ST_PDOWN    = 1;
    localparam int          EV_W        = 3;
    localparam int          EV_EXPIRE   = 0;
    localparam int          EV_WAKE     = 1;
    localparam int          EV_NOPSLEEP = 2;

    localparam int          CNT_W       = 24;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP
    } wdg_pwr_t;

    typedef struct packed {
        logic [4:0]       periodSel;
        logic             swEnable;
        logic             timeoutFlag;
        logic             powerdownFlag;
        logic [EV_W-1:0]  evStatus;
        logic [EV_W-1:0]  evEnable;
        logic [CNT_W-1:0] count;
        wdg_pwr_t         pwr;
        logic             deviceReset;
        logic             bValid;
        logic [1:0]       bResp;
        logic             rValid;
        logic [1:0]       rResp;
        logic [31:0]      rData;
    } wdg_state_t;

endpackage

// [wdg_watchdog.sv]
// Purpose: Watchdog period select, software enable and sleep/wake handling
// Assumes: One clock; synchronous active-low reset stands for power-on/brown-out
// Notes:   Summary of operation below
// Summary of operation
// - Period code picks power-of-two prescale, doubling
// - Period code resets to 01011
// - Codes 10011..11111 act as 1:32
// - Mode 01: software bit runs/stops watchdog
// - Mode 1x or 00: software bit ignored
// - Wake applies regardless of global interrupt enable
// - Pending interrupt makes sleep a no-op
// - Aborted sleep leaves counter and prescaler alone
// - Aborted sleep leaves timeout, powerdown flags alone
// - Later interrupt: complete sleep, wake immediately
// - Completed sleep clears counter and prescaler
// - Completed sleep sets timeout, clears powerdown
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
module wdg_watchdog (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [1:0]  configWatchMode,
    input  wire logic        sleepExec,
    input  wire logic        irqPending,
    output logic             asleep,
    output logic             deviceReset,
    output logic             irq,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    wdg_pkg::wdg_state_t s_r;
    wdg_pkg::wdg_state_t s_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [wdg_pkg::CNT_W-1:0] limitOf(input logic [4:0] code);
        logic [4:0] eff;
        eff = (code > wdg_pkg::PS_MAX) ? 5'h00 : code;
        limitOf = ({{(wdg_pkg::CNT_W-1){1'b0}}, 1'b1} << (eff + 5'(wdg_pkg::PS_BASE_LOG)))
                  - 1'b1;
    endfunction

    logic wdtRun;
    logic wrGo;
    logic rdGo;
    logic sleepAbort;
    logic sleepTake;
    logic [wdg_pkg::EV_W-1:0] evSet;
    logic [wdg_pkg::EV_W-1:0] clrMask;

    // Mode 01 gives software control; other modes hold the watchdog on
    assign wdtRun = (configWatchMode == wdg_pkg::MODE_SW) ? s_r.swEnable : 1'b1;
    assign sleepAbort = sleepExec && (s_r.pwr == wdg_pkg::PWR_RUN) && irqPending;
    assign sleepTake  = sleepExec && (s_r.pwr == wdg_pkg::PWR_RUN) && !irqPending;

    assign awready = awvalid && wvalid && !s_r.bValid;
    assign wready  = awready;
    assign wrGo    = awready;
    assign arready = arvalid && !s_r.rValid;
    assign rdGo    = arready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        evSet = '0;
        clrMask = '0;
        s_nxt.deviceReset = 1'b0;
        if (wdtRun) begin
            if (s_r.count >= limitOf(s_r.periodSel)) begin
                s_nxt.count = '0;
                s_nxt.deviceReset = 1'b1;
                s_nxt.timeoutFlag = 1'b0;
                s_nxt.pwr = wdg_pkg::PWR_RUN;
                evSet[wdg_pkg::EV_EXPIRE] = 1'b1;
            end else begin
                s_nxt.count = s_r.count + 1'b1;
            end
        end
        if (sleepAbort) begin
            evSet[wdg_pkg::EV_NOPSLEEP] = 1'b1;
        end
        if (sleepTake) begin
            s_nxt.count = '0;
            s_nxt.timeoutFlag = 1'b1;
            s_nxt.powerdownFlag = 1'b0;
            s_nxt.pwr = wdg_pkg::PWR_SLEEP;
        end
        if (s_r.pwr == wdg_pkg::PWR_SLEEP && irqPending) begin
            s_nxt.pwr = wdg_pkg::PWR_RUN;
            evSet[wdg_pkg::EV_WAKE] = 1'b1;
        end
        // Register writes
        s_nxt.bValid = s_r.bValid && !bready;
        if (wrGo) begin
            s_nxt.bValid = 1'b1;
            s_nxt.bResp = 2'h0;
            unique case (awaddr)
                wdg_pkg::OFF_CONTROL: begin
                    if (wstrb[0]) begin
                        s_nxt.periodSel = wdata[wdg_pkg::PS_LSB +: wdg_pkg::PS_W];
                        s_nxt.swEnable  = wdata[wdg_pkg::SWEN_BIT];
                    end
                end
                wdg_pkg::OFF_IRQ_EN: begin
                    if (wstrb[0]) s_nxt.evEnable = wdata[wdg_pkg::EV_W-1:0];
                end
                wdg_pkg::OFF_IRQ_CLR: begin
                    if (wstrb[0]) clrMask = wdata[wdg_pkg::EV_W-1:0];
                end
                wdg_pkg::OFF_STATUS: ;
                default: s_nxt.bResp = 2'h2;
            endcase
        end
        // Set wins over clear
        s_nxt.evStatus = (s_r.evStatus & ~clrMask) | evSet;
        // Register reads
        s_nxt.rValid = s_r.rValid && !rready;
        if (rdGo) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp = 2'h0;
            s_nxt.rData = '0;
            unique case (araddr)
                wdg_pkg::OFF_CONTROL: s_nxt.rData = {26'h0, s_r.periodSel, s_r.swEnable};
                wdg_pkg::OFF_STATUS:  s_nxt.rData = {27'h0, s_r.evStatus,
                                                     s_r.powerdownFlag, s_r.timeoutFlag};
                wdg_pkg::OFF_IRQ_EN:  s_nxt.rData = {29'h0, s_r.evEnable};
                wdg_pkg::OFF_IRQ_CLR: ;
                default:              s_nxt.rResp = 2'h2;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.periodSel <= wdg_pkg::PS_RESET;
            s_r.timeoutFlag <= 1'b1;
            s_r.powerdownFlag <= 1'b1;
            s_r.pwr <= wdg_pkg::PWR_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign asleep      = (s_r.pwr == wdg_pkg::PWR_SLEEP);
    assign deviceReset = s_r.deviceReset;
    assign irq         = |(s_r.evStatus & s_r.evEnable);
    assign bvalid      = s_r.bValid;
    assign bresp       = s_r.bResp;
    assign rvalid      = s_r.rValid;
    assign rresp       = s_r.rResp;
    assign rdata       = s_r.rData;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_code;
        @(posedge clock) $rose(reset_n) |-> s_r.periodSel == wdg_pkg::PS_RESET;
    endproperty
    a_reset_code: assert property (p_reset_code) else $error("bad period reset");

    property p_sw_stop;
        @(posedge clock) disable iff (!reset_n)
        (configWatchMode == 2'h1 && !s_r.swEnable && !sleepTake) |=> s_r.count == $past(s_r.count);
    endproperty
    a_sw_stop: assert property (p_sw_stop) else $error("watchdog ran while stopped");

    property p_sw_ignored;
        @(posedge clock) disable iff (!reset_n)
        (configWatchMode != 2'h1 && !sleepTake && !s_r.deviceReset && !deviceReset &&
         s_r.count < limitOf(s_r.periodSel)) |=> s_r.count == $past(s_r.count) + 1'b1;
    endproperty
    a_sw_ignored: assert property (p_sw_ignored) else $error("enable bit not ignored");

    property p_abort;
        @(posedge clock) disable iff (!reset_n)
        sleepAbort |=> !asleep && s_r.timeoutFlag == $past(s_r.timeoutFlag)
                       && s_r.powerdownFlag == $past(s_r.powerdownFlag);
    endproperty
    a_abort: assert property (p_abort) else $error("aborted sleep changed state");

    property p_abort_count;
        @(posedge clock) disable iff (!reset_n)
        (sleepAbort && wdtRun && s_r.count < limitOf(s_r.periodSel))
            |=> s_r.count == $past(s_r.count) + 1'b1;
    endproperty
    a_abort_count: assert property (p_abort_count) else $error("aborted sleep cleared count");

    property p_take;
        @(posedge clock) disable iff (!reset_n)
        sleepTake |=> asleep && s_r.count == 0 && s_r.timeoutFlag && !s_r.powerdownFlag;
    endproperty
    a_take: assert property (p_take) else $error("sleep entry wrong");

    property p_wake;
        @(posedge clock) disable iff (!reset_n)
        (asleep && irqPending) |=> !asleep;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");

    property p_expire;
        @(posedge clock) disable iff (!reset_n)
        (wdtRun && !sleepTake && s_r.count >= limitOf(s_r.periodSel))
            |=> deviceReset ##1 !deviceReset;
    endproperty
    a_expire: assert property (p_expire) else $error("no reset on expiry");

    property p_reserved;
        @(posedge clock) disable iff (!reset_n)
        s_r.periodSel > 5'h12 |-> limitOf(s_r.periodSel) == 24'h00001F;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not minimum");

    // ------------------------------------------------------------
    // Flag, event and register checks
    // ------------------------------------------------------------
    property p_expire_state;
        @(posedge clock) disable iff (!reset_n)
        (wdtRun && !sleepTake && s_r.count >= limitOf(s_r.periodSel))
            |=> s_r.count == 0 && !s_r.timeoutFlag && !asleep;
    endproperty
    a_expire_state: assert property (p_expire_state) else $error("expiry state wrong");

    property p_expire_event;
        @(posedge clock) disable iff (!reset_n)
        deviceReset |-> s_r.evStatus[wdg_pkg::EV_EXPIRE];
    endproperty
    a_expire_event: assert property (p_expire_event) else $error("expiry not recorded");

    property p_wake_event;
        @(posedge clock) disable iff (!reset_n)
        (asleep && irqPending) |=> s_r.evStatus[wdg_pkg::EV_WAKE];
    endproperty
    a_wake_event: assert property (p_wake_event) else $error("wake not recorded");

    property p_nop_event;
        @(posedge clock) disable iff (!reset_n)
        sleepAbort |=> s_r.evStatus[wdg_pkg::EV_NOPSLEEP];
    endproperty
    a_nop_event: assert property (p_nop_event) else $error("no-op sleep not recorded");

    property p_stay_asleep;
        @(posedge clock) disable iff (!reset_n)
        (asleep && !irqPending && !(wdtRun && s_r.count >= limitOf(s_r.periodSel)))
            |=> asleep;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep early");

    property p_to_rise;
        @(posedge clock) disable iff (!reset_n)
        ($rose(s_r.timeoutFlag) && $past(reset_n))
            |-> $past(sleepTake);
    endproperty
    a_to_rise: assert property (p_to_rise) else $error("timeout flag set without sleep");

    property p_pd_fall;
        @(posedge clock) disable iff (!reset_n)
        ($fell(s_r.powerdownFlag) && $past(reset_n))
            |-> $past(sleepTake);
    endproperty
    a_pd_fall: assert property (p_pd_fall) else $error("powerdown flag cleared early");

    property p_rst_flags;
        @(posedge clock)
        $rose(reset_n) |-> s_r.timeoutFlag && s_r.powerdownFlag && !asleep;
    endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("flags wrong after reset");

    property p_set_wins;
        @(posedge clock) disable iff (!reset_n)
        (|evSet)
            |=> (s_r.evStatus & $past(evSet)) == $past(evSet);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_sw_run;
        @(posedge clock) disable iff (!reset_n)
        (configWatchMode == 2'h1 && s_r.swEnable && !sleepTake &&
         s_r.count < limitOf(s_r.periodSel)) |=> s_r.count == $past(s_r.count) + 1'b1;
    endproperty
    a_sw_run: assert property (p_sw_run) else $error("watchdog stopped while on");

    property p_period_write;
        @(posedge clock) disable iff (!reset_n)
        (wrGo && awaddr == wdg_pkg::OFF_CONTROL && wstrb[0])
            |=> {26'h0, s_r.periodSel, s_r.swEnable} == ($past(wdata) & 32'h0000003F);
    endproperty
    a_period_write: assert property (p_period_write) else $error("control write lost");

endmodule

// [test_wdg_watchdog.sv]
// Purpose: Self-checking bench for the watchdog period and sleep-wake block
// Assumes: Short period codes keep every expiry within a few hundred cycles
// Notes:   Registers reached through AXI4-Lite tasks; settled values read at negedge
`timescale 1ns/1ps
module test_wdg_watchdog;
    // --------------------
    // Signals
    // --------------------
    logic        clock, reset_n, sleepExec, irqPending, asleep, deviceReset, irq;
    logic [1:0]  configWatchMode, bresp, rresp, rs, bs;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [4:0]  codes [5] = '{5'h1F, 5'h13, 5'h00, 5'h01, 5'h02};
    int          failures, cmpCount, cyc, rstCnt, t0;

    wdg_watchdog u_dut (.clock, .reset_n, .configWatchMode, .sleepExec, .irqPending,
        .asleep, .deviceReset, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) cyc <= cyc + 1;
    always @(negedge clock) if (deviceReset === 1'b1) rstCnt++;

    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int expIvl(input logic [4:0] c);
        return c > wdg_pkg::PS_MAX ? 32 : 1 << (c + wdg_pkg::PS_BASE_LOG);
    endfunction

    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clock);
            aw = awready;
            w = wready;
            b = bvalid === 1'b1;
            bs = bresp;
            @(posedge clock);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        @(negedge clock);
    endtask

    task automatic rdReg(input logic [3:0] a);
        logic ar, v;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clock);
            ar = arready;
            v = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            @(posedge clock);
            if (ar) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
    endtask

    task automatic waitRst;
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 5000 && !seen; n++) begin
            @(negedge clock);
            seen = deviceReset === 1'b1;
        end
        check(seen, 1'b1);
    endtask

    task automatic sleepReq(input logic pend);
        @(posedge clock);
        irqPending <= pend;
        sleepExec <= 1'b1;
        @(posedge clock);
        sleepExec <= 1'b0;
        @(negedge clock);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // --------------------
    // Sequence
    // --------------------
    initial begin
        repeat (40000) @(posedge clock);
        failures++;
        print_verdict;
    end

    initial begin
        logic [4:0] c;
        {sleepExec, irqPending, awvalid, wvalid, arvalid, bready, rready} = '0;
        {reset_n, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        configWatchMode = wdg_pkg::MODE_SW;
        c = 5'($urandom(32'hB000A208));
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        rdReg(wdg_pkg::OFF_CONTROL);
        check(rd, {26'h0, wdg_pkg::PS_RESET, 1'b0});
        rdReg(wdg_pkg::OFF_STATUS);
        check(rd[4:0], 5'h03);
        rdReg(4'h2);
        check(rs, 2'h2);
        wrReg(4'h2, 32'h0);
        check(bs, 2'h2);
        repeat (8) begin
            c = 5'($urandom_range(18));
            wrReg(wdg_pkg::OFF_CONTROL, {26'h0, c, 1'b0});
            check(bs, 2'h0);
            rdReg(wdg_pkg::OFF_CONTROL);
            check(rd[5:0], {c, 1'b0});
        end
        // Limits never fall along the list so a running count never passes the new one
        foreach (codes[i]) begin
            wrReg(wdg_pkg::OFF_CONTROL, {26'h0, codes[i], 1'b1});
            waitRst;
            t0 = cyc;
            waitRst;
            check(cyc - t0 inside {[expIvl(codes[i]) - 1 : expIvl(codes[i]) + 2]}, 1);
        end
        wrReg(wdg_pkg::OFF_CONTROL, 32'h0);
        for (int m = 0; m < 4; m++) begin
            @(posedge clock);
            configWatchMode <= 2'(m);
            t0 = rstCnt;
            repeat (200) @(posedge clock);
            check(rstCnt != t0, m != 1);
        end
        configWatchMode <= wdg_pkg::MODE_SW;
        // Watchdog running so the aborted sleep must leave the count going
        wrReg(wdg_pkg::OFF_CONTROL, {26'h0, 5'h02, 1'b1});
        sleepReq(1'b1);
        check(asleep, 1'b0);
        rdReg(wdg_pkg::OFF_STATUS);
        check(rd[4:0], 5'h16);
        sleepReq(1'b0);
        t0 = cyc;
        check(asleep, 1'b1);
        rdReg(wdg_pkg::OFF_STATUS);
        check(rd[1:0], 2'h1);
        irqPending <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        check(asleep, 1'b0);
        waitRst;
        check(cyc - t0 inside {[126:130]}, 1);
        wrReg(wdg_pkg::OFF_CONTROL, 32'h0);
        wrReg(wdg_pkg::OFF_IRQ_EN, 32'h0);
        check(irq, 1'b0);
        wrReg(wdg_pkg::OFF_IRQ_EN, 32'h2);
        check(irq, 1'b1);
        wrReg(wdg_pkg::OFF_IRQ_CLR, 32'h2);
        check(irq, 1'b0);
        rdReg(wdg_pkg::OFF_IRQ_CLR);
        check(rd, 32'h0);
        print_verdict;
    end
endmodule
